// File: shared/pdc_pkg.sv
/*
 * Constants for the packet-driven memory channel core: register offsets,
 * packet field positions, opcode values, reset values and the transmit states.
 * Assumes nothing; every design file names these as pdc_pkg::name.
 */
package pdc_pkg;
	// ************************************************
	// packet shape
	// ************************************************
	localparam int BEATS      = 8;
	localparam int ROW_LANES  = 3;
	localparam int COL_LANES  = 5;
	localparam int DATA_LANES = 9;
	// row packet, 24 bits, first beat in the top bits
	localparam int ROW_FT      = 23;
	localparam int ROW_FF      = 22;
	localparam int ROW_DEV_HI  = 21;
	localparam int ROW_DEV_LO  = 18;
	localparam int ROW_BANK_HI = 17;
	localparam int ROW_BANK_LO = 13;
	localparam int ROW_TYPE    = 12;
	localparam int ROW_ADDR_HI = 8;
	localparam int ROW_OP_HI   = 10;
	// column packet (23 bits) followed by companion packet (17 bits)
	localparam int COL_DEV_HI  = 38;
	localparam int COL_DEV_LO  = 34;
	localparam int COL_BANK_HI = 33;
	localparam int COL_BANK_LO = 29;
	localparam int COL_COL_HI  = 28;
	localparam int COL_COL_LO  = 23;
	localparam int COL_OP_HI   = 22;
	localparam int COL_OP_LO   = 19;
	localparam int COL_SEL     = 16;
	localparam int COL_MASK_HI = 15;
	localparam int XOP_DEV_HI  = 14;
	localparam int XOP_DEV_LO  = 10;
	localparam int XOP_BANK_HI = 9;
	localparam int XOP_BANK_LO = 5;
	localparam int XOP_OP_HI   = 4;
	// ************************************************
	// opcodes
	// ************************************************
	localparam logic [1:0]  COP_NOOP      = 2'h0;
	localparam logic [1:0]  COP_WRITE     = 2'h1;
	localparam logic [1:0]  COP_READ      = 2'h2;
	localparam int          COP_CLOSE_BIT = 2;
	localparam logic [10:0] ROWOP_CLOSE   = 11'h001;
	localparam logic [4:0]  XOP_CLOSE     = 5'h01;
	localparam logic [15:0] MASK_ALL      = 16'hFFFF;
	// ************************************************
	// registers
	// ************************************************
	localparam logic [3:0] REG_DEV_ID  = 4'h0;
	localparam logic [3:0] REG_ROW_CNT = 4'h4;
	localparam logic [3:0] REG_OPEN    = 4'h8;
	localparam logic [3:0] REG_STATUS  = 4'hC;
	localparam int         ST_WBUF     = 0;
	localparam int         ST_TXBUSY   = 1;
	localparam int         ST_CONFLICT = 2;
	localparam logic [4:0] DEV_ID_RST  = 5'h00;
	localparam logic [8:0] ROW_CNT_RST = 9'h000;
	typedef enum logic [1:0] {
		PDC_TX_IDLE  = 2'b00,
		PDC_TX_LOAD  = 2'b01,
		PDC_TX_DRIVE = 2'b11
	} pdc_tx_state_type;
endpackage : pdc_pkg

// File: src/pdc_deser.sv
/*
 * Gathers a fixed number of beats from a group of lanes into one packet.
 * Assumes beat is a one-cycle pulse on each sampled rising link clock edge.
 */
`timescale 1ns/1ps
module pdc_deser #(
	parameter int               LANES      = 3,
	parameter int               BEATS      = 8,
	parameter logic [LANES-1:0] FRAME_MASK = '0
)(
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire logic                   clk_en,
	input  wire logic                   beat,
	input  wire logic                   arm,
	input  wire logic [LANES-1:0]       din,
	output logic      [LANES*BEATS-1:0] pkt,
	output logic                        done
);
	localparam int CNTW = $clog2(BEATS);
	logic [LANES*BEATS-1:0] shift_reg;
	logic [CNTW-1:0]        cnt_reg;
	logic                   start;
	logic                   take;

	// an all-zero frame mask means the arm input alone frames the packet
	assign start = beat && arm && (cnt_reg == '0) && (FRAME_MASK == '0 || |(din & FRAME_MASK));
	assign take  = start || (beat && cnt_reg != '0);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			shift_reg <= '0;
			cnt_reg   <= '0;
			pkt       <= '0;
			done      <= 1'b0;
		end
		else if (clk_en)
		begin
			done <= 1'b0;
			if (take)
			begin
				shift_reg <= {shift_reg[LANES*BEATS-LANES-1:0], din};
				cnt_reg   <= (cnt_reg == CNTW'(BEATS-1)) ? '0 : cnt_reg + 1'b1;
				if (cnt_reg == CNTW'(BEATS-1))
				begin
					pkt  <= {shift_reg[LANES*BEATS-LANES-1:0], din};
					done <= 1'b1;
				end
			end
		end
	end
endmodule : pdc_deser

// File: src/pdc_channel_core.sv
/*
 * Device side of a packet-driven, 32-bank memory channel: request and data
 * lanes, bank and sense-amp state, write buffer, read transmit and a small
 * register port. Assumes all channel pins and both link clocks are
 * asynchronous to clock and far slower than it.
 */
// Local design decisions: the address map and the strobed register port.
// What this block does
// RL1: sideband and register signals are active high
// RL2: channel lanes and clocks are active low
// RL3: three row lanes form 24-bit row packets
// RL4: five column lanes form 23+17 bit packets
// RL5: 18 data pins map to two 72-bit paths
// RL6: narrow build leaves ninth lane bit unused
// RL7: read data driven on transmit clock edges
// RL8: receive clock captures requests and write data
// RL9: 32 banks, 512 rows, 64 dualocts each
// RL10: adjacent banks share sense amps, never both
// RL11: row open loads row into sense amps
// RL12: bank close releases the bank's sense amps
// RL13: column read sends dualoct on both lanes
// RL14: column write fills buffer, retired with mask
// RL15: retire on other-device command or own write/no-op
// RL16: own read in progress holds the buffer
// RL17: auto-close column commands close after operation
// RL18: extended packet may carry independent close
// RL19: five-bit device id selects channel address
// RL20: nine-bit row counter held in registers
// RL21: register access over serial control pins; a plain strobed port here
// RL22: upper three lanes row, lower five column
// RL23: row type bit: one opens, zero operates
// RL24: companion select bit: mask or extended
// RL25: mask bit one writes, bit zero earliest
// RL26: both frame bits broadcast, neither no packet
// RL27: controller opens a row before column access
`timescale 1ns/1ps
module pdc_channel_core #(
	parameter int BANKS = 32,
	parameter int ROWS  = 512,
	parameter int COLS  = 64,
	parameter bit WIDE  = 1'b1
)(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        clk_en,
	input  wire logic        receive_clock_pair_from_master_p,
	input  wire logic        receive_clock_pair_from_master_n,
	input  wire logic        transmit_clock_pair_to_master_p,
	input  wire logic        transmit_clock_pair_to_master_n,
	input  wire logic [7:0]  request_pins,
	input  wire logic [8:0]  data_byte_lane_a_in,
	output logic      [8:0]  data_byte_lane_a_out,
	output logic      [8:0]  data_byte_lane_a_oe,
	input  wire logic [8:0]  data_byte_lane_b_in,
	output logic      [8:0]  data_byte_lane_b_out,
	output logic      [8:0]  data_byte_lane_b_oe,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata
);
	localparam int BW = $clog2(BANKS);
	localparam int RW = $clog2(ROWS);
	localparam int CW = $clog2(COLS);
	localparam int AW = BW + RW + CW;
	localparam int DW = pdc_pkg::DATA_LANES * pdc_pkg::BEATS;
	localparam int TXC = $clog2(pdc_pkg::BEATS + 1);

	// ************************************************
	// pin synchronisers and link clock edges
	// ************************************************
	logic [29:0] pin_meta_reg;
	logic [29:0] pin_sync_reg;
	logic        rx_prev_reg;
	logic        tx_prev_reg;
	logic        rx_lvl;
	logic        tx_lvl;
	logic        rx_beat;
	logic        tx_beat;
	logic [2:0]  row_lanes;
	logic [4:0]  col_lanes;
	logic [8:0]  lane_a;
	logic [8:0]  lane_b;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
			rx_prev_reg  <= 1'b0;
			tx_prev_reg  <= 1'b0;
		end
		else if (clk_en)
		begin
			pin_meta_reg <= {receive_clock_pair_from_master_p, receive_clock_pair_from_master_n,
				transmit_clock_pair_to_master_p, transmit_clock_pair_to_master_n,
				request_pins, data_byte_lane_a_in, data_byte_lane_b_in};
			pin_sync_reg <= pin_meta_reg;
			rx_prev_reg  <= rx_lvl;
			tx_prev_reg  <= tx_lvl;
		end
	end

	// a pair counts as high only when its two halves disagree the right way
	assign rx_lvl    = pin_sync_reg[29] & ~pin_sync_reg[28];  // [RL8]
	assign tx_lvl    = pin_sync_reg[27] & ~pin_sync_reg[26];  // [RL7]
	assign rx_beat   = rx_lvl & ~rx_prev_reg;
	assign tx_beat   = tx_lvl & ~tx_prev_reg;
	assign row_lanes = ~pin_sync_reg[25:23];  // [RL2] [RL22]
	assign col_lanes = ~pin_sync_reg[22:18];  // [RL2] [RL22]
	assign lane_a    = ~pin_sync_reg[17:9] & {WIDE, 8'hFF};  // [RL2] [RL6]
	assign lane_b    = ~pin_sync_reg[8:0] & {WIDE, 8'hFF};   // [RL2] [RL6]

	// ************************************************
	// packet and data assembly
	// ************************************************
	logic [23:0]   row_pkt;
	logic          row_done;
	logic [39:0]   col_pkt;
	logic          col_done;
	logic [DW-1:0] wd_a;
	logic [DW-1:0] wd_b;
	logic          wd_done;
	logic          wr_wait_reg;

	pdc_deser #(.LANES(pdc_pkg::ROW_LANES), .BEATS(pdc_pkg::BEATS), .FRAME_MASK(3'b110)) u_row (  // [RL3]
		.clock(clock), .rst(rst), .clk_en(clk_en), .beat(rx_beat), .arm(1'b1),
		.din(row_lanes), .pkt(row_pkt), .done(row_done));
	pdc_deser #(.LANES(pdc_pkg::COL_LANES), .BEATS(pdc_pkg::BEATS), .FRAME_MASK(5'b10000)) u_col (  // [RL4]
		.clock(clock), .rst(rst), .clk_en(clk_en), .beat(rx_beat), .arm(1'b1),
		.din(col_lanes), .pkt(col_pkt), .done(col_done));
	pdc_deser #(.LANES(pdc_pkg::DATA_LANES), .BEATS(pdc_pkg::BEATS), .FRAME_MASK(9'h000)) u_da (  // [RL5]
		.clock(clock), .rst(rst), .clk_en(clk_en), .beat(rx_beat), .arm(wr_wait_reg),
		.din(lane_a), .pkt(wd_a), .done(wd_done));
	pdc_deser #(.LANES(pdc_pkg::DATA_LANES), .BEATS(pdc_pkg::BEATS), .FRAME_MASK(9'h000)) u_db (  // [RL5]
		.clock(clock), .rst(rst), .clk_en(clk_en), .beat(rx_beat), .arm(wr_wait_reg),
		.din(lane_b), .pkt(wd_b), .done());

	// ************************************************
	// decode
	// ************************************************
	logic [4:0]    dev_id_reg;
	logic [8:0]    row_cnt_reg;
	logic [BANKS-1:0] open_reg;
	logic [RW-1:0] open_row_reg [BANKS];
	logic          row_ft;
	logic          row_ff;
	logic          row_match;
	logic [BW-1:0] row_bank;
	logic          row_act;
	logic          row_close;
	logic          conflict;
	logic          c_self;
	logic [BW-1:0] c_bank;
	logic [1:0]    c_op;
	logic          self_rd;
	logic          self_wr;
	logic          auto_close;
	logic          x_close;
	logic          retire;
	logic          wbuf_valid_reg;
	pdc_pkg::pdc_tx_state_type tx_state_reg;

	assign row_ft    = row_pkt[pdc_pkg::ROW_FT];
	assign row_ff    = row_pkt[pdc_pkg::ROW_FF];
	// neither frame bit means nothing is there; both is broadcast
	assign row_match = (row_ft & row_ff)
		| ((row_ft ^ row_ff) & (dev_id_reg == {row_ft, row_pkt[pdc_pkg::ROW_DEV_HI:pdc_pkg::ROW_DEV_LO]}));  // [RL26] [RL19]
	assign row_bank  = BW'(row_pkt[pdc_pkg::ROW_BANK_HI:pdc_pkg::ROW_BANK_LO]);
	assign row_act   = row_done && row_match && row_pkt[pdc_pkg::ROW_TYPE];  // [RL23]
	assign row_close = row_done && row_match && !row_pkt[pdc_pkg::ROW_TYPE]
		&& row_pkt[pdc_pkg::ROW_OP_HI:0] == pdc_pkg::ROWOP_CLOSE;  // [RL23]
	// the two end banks of each half own their outer amp alone
	assign conflict  = row_act && (((row_bank[3:0] != 4'h0) && open_reg[row_bank - 1'b1])
		|| ((row_bank[3:0] != 4'hF) && open_reg[row_bank + 1'b1]));  // [RL10]

	assign c_self     = col_pkt[pdc_pkg::COL_DEV_HI:pdc_pkg::COL_DEV_LO] == dev_id_reg;  // [RL19]
	assign c_bank     = BW'(col_pkt[pdc_pkg::COL_BANK_HI:pdc_pkg::COL_BANK_LO]);
	assign c_op       = col_pkt[pdc_pkg::COL_OP_LO+1:pdc_pkg::COL_OP_LO];
	assign self_rd    = col_done && c_self && c_op == pdc_pkg::COP_READ && open_reg[c_bank];
	assign self_wr    = col_done && c_self && c_op == pdc_pkg::COP_WRITE && open_reg[c_bank];
	assign auto_close = col_done && c_self && col_pkt[pdc_pkg::COL_OP_LO+pdc_pkg::COP_CLOSE_BIT];  // [RL17]
	assign x_close    = col_done && !col_pkt[pdc_pkg::COL_SEL]
		&& col_pkt[pdc_pkg::XOP_DEV_HI:pdc_pkg::XOP_DEV_LO] == dev_id_reg
		&& col_pkt[pdc_pkg::XOP_OP_HI:0] == pdc_pkg::XOP_CLOSE;  // [RL24] [RL18]
	// any command elsewhere, or own write or no-op, and no own read on the wire
	assign retire     = col_done && wbuf_valid_reg && tx_state_reg == pdc_pkg::PDC_TX_IDLE
		&& (!c_self || c_op == pdc_pkg::COP_WRITE || c_op == pdc_pkg::COP_NOOP);  // [RL15] [RL16]

	// ************************************************
	// bank and sense-amp state
	// ************************************************
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			open_reg <= '0;
			for (int i = 0; i < BANKS; i++)
				open_row_reg[i] <= '0;
		end
		else if (clk_en)
		begin
			if (row_act && !conflict)
			begin
				open_reg[row_bank]     <= 1'b1;  // [RL11]
				open_row_reg[row_bank] <= RW'(row_pkt[pdc_pkg::ROW_ADDR_HI:0]);  // [RL11]
			end
			if (row_close)
				open_reg[row_bank] <= 1'b0;  // [RL12]
			if (auto_close)
				open_reg[c_bank] <= 1'b0;  // [RL17]
			if (x_close)
				open_reg[BW'(col_pkt[pdc_pkg::XOP_BANK_HI:pdc_pkg::XOP_BANK_LO])] <= 1'b0;  // [RL18]
		end
	end

	// ************************************************
	// write buffer
	// ************************************************
	logic [AW-1:0] wr_addr_reg;
	logic [15:0]   wr_mask_reg;
	logic [DW-1:0] wbuf_a_reg;
	logic [DW-1:0] wbuf_b_reg;
	logic [AW-1:0] wbuf_addr_reg;
	logic [15:0]   wbuf_mask_reg;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wr_wait_reg    <= 1'b0;
			wr_addr_reg    <= '0;
			wr_mask_reg    <= '0;
			wbuf_valid_reg <= 1'b0;
			wbuf_a_reg     <= '0;
			wbuf_b_reg     <= '0;
			wbuf_addr_reg  <= '0;
			wbuf_mask_reg  <= '0;
		end
		else if (clk_en)
		begin
			if (self_wr)
			begin
				wr_wait_reg <= 1'b1;
				wr_addr_reg <= {c_bank, open_row_reg[c_bank],
					CW'(col_pkt[pdc_pkg::COL_COL_HI:pdc_pkg::COL_COL_LO])};  // [RL14]
				wr_mask_reg <= col_pkt[pdc_pkg::COL_SEL] ? col_pkt[pdc_pkg::COL_MASK_HI:0]
					: pdc_pkg::MASK_ALL;  // [RL24]
			end
			else if (wd_done)
				wr_wait_reg <= 1'b0;
			if (wd_done)
			begin
				wbuf_valid_reg <= 1'b1;  // [RL14]
				wbuf_a_reg     <= wd_a;
				wbuf_b_reg     <= wd_b;
				wbuf_addr_reg  <= wr_addr_reg;
				wbuf_mask_reg  <= wr_mask_reg;
			end
			else if (retire)
				wbuf_valid_reg <= 1'b0;
		end
	end

	// ************************************************
	// storage core, one array per data path
	// ************************************************
	logic [DW-1:0] core_a [BANKS*ROWS*COLS];  // [RL9] [RL5]
	logic [DW-1:0] core_b [BANKS*ROWS*COLS];
	logic [AW-1:0] rd_addr_reg;

	always_ff @(posedge clock)
	begin
		if (clk_en && retire)
		begin
			// byte k sits at beat k; lane b's earliest byte is mask bit 0, lane a's is mask bit 8
			for (int k = 0; k < pdc_pkg::BEATS; k++)
			begin
				if (wbuf_mask_reg[8+k])
					core_a[wbuf_addr_reg][(7-k)*9 +: 9] <= wbuf_a_reg[(7-k)*9 +: 9];  // [RL25] [RL14]
				if (wbuf_mask_reg[k])
					core_b[wbuf_addr_reg][(7-k)*9 +: 9] <= wbuf_b_reg[(7-k)*9 +: 9];  // [RL25]
			end
		end
	end

	// ************************************************
	// read transmit
	// ************************************************
	logic [DW-1:0]  tx_a_reg;
	logic [DW-1:0]  tx_b_reg;
	logic [TXC-1:0] tx_cnt_reg;
	logic [8:0]     dq_a_reg;
	logic [8:0]     dq_b_reg;
	logic           dq_oe_reg;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			tx_state_reg <= pdc_pkg::PDC_TX_IDLE;
			rd_addr_reg  <= '0;
			tx_a_reg     <= '0;
			tx_b_reg     <= '0;
			tx_cnt_reg   <= '0;
			dq_a_reg     <= 9'h1FF;
			dq_b_reg     <= 9'h1FF;
			dq_oe_reg    <= 1'b0;
		end
		else if (clk_en)
		begin
			case (tx_state_reg)
				pdc_pkg::PDC_TX_IDLE:
				begin
					// a second own read while busy is dropped
					if (self_rd)
					begin
						rd_addr_reg  <= {c_bank, open_row_reg[c_bank],
							CW'(col_pkt[pdc_pkg::COL_COL_HI:pdc_pkg::COL_COL_LO])};  // [RL13]
						tx_state_reg <= pdc_pkg::PDC_TX_LOAD;
					end
				end
				pdc_pkg::PDC_TX_LOAD:
				begin
					tx_a_reg     <= core_a[rd_addr_reg];
					tx_b_reg     <= core_b[rd_addr_reg];
					tx_cnt_reg   <= '0;
					tx_state_reg <= pdc_pkg::PDC_TX_DRIVE;
				end
				pdc_pkg::PDC_TX_DRIVE:
				begin
					if (tx_beat)
					begin
						if (tx_cnt_reg == TXC'(pdc_pkg::BEATS))
						begin
							dq_oe_reg    <= 1'b0;
							dq_a_reg     <= 9'h1FF;
							dq_b_reg     <= 9'h1FF;
							tx_state_reg <= pdc_pkg::PDC_TX_IDLE;
						end
						else
						begin
							dq_oe_reg  <= 1'b1;  // [RL7] [RL13]
							dq_a_reg   <= ~tx_a_reg[DW-1 -: 9];  // [RL2]
							dq_b_reg   <= ~tx_b_reg[DW-1 -: 9];  // [RL2]
							tx_a_reg   <= {tx_a_reg[DW-10:0], 9'h000};
							tx_b_reg   <= {tx_b_reg[DW-10:0], 9'h000};
							tx_cnt_reg <= tx_cnt_reg + 1'b1;
						end
					end
				end
				default:
					tx_state_reg <= pdc_pkg::PDC_TX_IDLE;
			endcase
		end
	end

	assign data_byte_lane_a_out = dq_a_reg;
	assign data_byte_lane_b_out = dq_b_reg;
	assign data_byte_lane_a_oe  = {dq_oe_reg & WIDE, {8{dq_oe_reg}}};  // [RL6]
	assign data_byte_lane_b_oe  = {dq_oe_reg & WIDE, {8{dq_oe_reg}}};  // [RL6]

	// ************************************************
	// control registers
	// ************************************************
	logic conflict_reg;

	// the plain port stands in for the serial control access
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			dev_id_reg   <= pdc_pkg::DEV_ID_RST;
			row_cnt_reg  <= pdc_pkg::ROW_CNT_RST;
			conflict_reg <= 1'b0;
			reg_rdata    <= '0;
		end
		else if (clk_en)
		begin
			if (reg_wr && reg_addr == pdc_pkg::REG_DEV_ID)
				dev_id_reg <= reg_wdata[4:0];  // [RL19] [RL21] [RL1]
			if (reg_wr && reg_addr == pdc_pkg::REG_ROW_CNT)
				row_cnt_reg <= reg_wdata[8:0];  // [RL20]
			// a new conflict beats a clear in the same cycle
			if (conflict)
				conflict_reg <= 1'b1;
			else if (reg_wr && reg_addr == pdc_pkg::REG_STATUS && reg_wdata[pdc_pkg::ST_CONFLICT])
				conflict_reg <= 1'b0;
			reg_rdata <= '0;
			if (reg_rd)
			begin
				if (reg_addr == pdc_pkg::REG_DEV_ID)
					reg_rdata <= 32'(dev_id_reg);
				else if (reg_addr == pdc_pkg::REG_ROW_CNT)
					reg_rdata <= 32'(row_cnt_reg);  // [RL20]
				else if (reg_addr == pdc_pkg::REG_OPEN)
					reg_rdata <= 32'(open_reg);
				else if (reg_addr == pdc_pkg::REG_STATUS)
					reg_rdata <= 32'({conflict_reg, tx_state_reg != pdc_pkg::PDC_TX_IDLE, wbuf_valid_reg});
			end
		end
	end

	// ************************************************
	// assertions
	// ************************************************
	sequence s_read_issue;
		clk_en && self_rd && tx_state_reg == pdc_pkg::PDC_TX_IDLE;
	endsequence
	sequence s_drive_seen;
		##[1:40] dq_oe_reg;
	endsequence

	property p_read_drive;
		@(posedge clock) disable iff (rst) s_read_issue |-> s_drive_seen;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read not driven in time");  // [RL13]

	property p_open;
		@(posedge clock) disable iff (rst) (clk_en && row_act && !conflict) |=> open_reg[$past(row_bank)];
	endproperty
	a_open: assert property (p_open) else $error("row open did not mark bank");  // [RL11]

	property p_close;
		@(posedge clock) disable iff (rst) (clk_en && row_close && !row_act) |=> !open_reg[$past(row_bank)];
	endproperty
	a_close: assert property (p_close) else $error("bank close ignored");  // [RL12]

	property p_conflict;
		@(posedge clock) disable iff (rst)
			(clk_en && conflict && !open_reg[row_bank]) |=> !open_reg[$past(row_bank)] && conflict_reg;
	endproperty
	a_conflict: assert property (p_conflict) else $error("adjacent bank opened");  // [RL10]

	property p_hold;
		@(posedge clock) disable iff (rst)
			(clk_en && wbuf_valid_reg && tx_state_reg != pdc_pkg::PDC_TX_IDLE) |=> wbuf_valid_reg;
	endproperty
	a_hold: assert property (p_hold) else $error("buffer retired during own read");  // [RL16]

	property p_fill;
		@(posedge clock) disable iff (rst) (clk_en && wd_done) |=> wbuf_valid_reg && !wr_wait_reg;
	endproperty
	a_fill: assert property (p_fill) else $error("write data not buffered");  // [RL14]

	property p_auto;
		@(posedge clock) disable iff (rst) (clk_en && auto_close && !row_act) |=> !open_reg[$past(c_bank)];
	endproperty
	a_auto: assert property (p_auto) else $error("auto close missed");  // [RL17]

	property p_noframe;
		@(posedge clock) disable iff (rst) row_done |-> (row_ft || row_ff);
	endproperty
	a_noframe: assert property (p_noframe) else $error("unframed row packet reached decode");  // [RL26]

	property p_narrow;
		@(posedge clock) disable iff (rst) !WIDE |-> !data_byte_lane_a_oe[8] && !data_byte_lane_b_oe[8];
	endproperty
	a_narrow: assert property (p_narrow) else $error("ninth bit driven in narrow build");  // [RL6]
endmodule : pdc_channel_core

// File: tb/pdc_ctl_model.sv
/* controller model: request lanes, write data and both link clocks.
   assumes the core samples all of these with its own clock. */
`timescale 1ns/1ps
module pdc_ctl_model (
	output logic       rx_p,
	output logic       rx_n,
	output logic       tx_p,
	output logic       tx_n,
	output logic [7:0] request_pins,
	output logic [8:0] lane_a,
	output logic [8:0] lane_b
);
	logic [7:0] rq = 8'h00;
	initial
	begin
		{rx_p, tx_p, lane_a, lane_b} = {2'b00, 18'h3FFFF};
		#7;
		forever #160 rx_p = ~rx_p;
	end
	// offset keeps link edges off the system edges
	always @(rx_p) tx_p <= #50 rx_p;
	assign {rx_n, tx_n} = ~{rx_p, tx_p};
	assign request_pins = ~rq;
	task automatic send(input logic col, input logic [39:0] p, input logic wr, input logic [71:0] a,
		input logic [71:0] b);
		for (int j = 0; j < (wr ? 16 : 8); j++)
		begin
			@(negedge rx_p);
			if (col)
				rq[4:0] <= (j < 8) ? p[(7-j)*5 +: 5] : 5'h00;
			else
				rq[7:5] <= p[(7-j)*3 +: 3];
			if (j > 7)
				{lane_a, lane_b} <= ~{a[(j-8)*9 +: 9], b[(j-8)*9 +: 9]};
		end
		@(negedge rx_p);
		rq <= 8'h00;
		// released lanes float back to the terminated idle level, logic zero
		{lane_a, lane_b} <= 18'h3FFFF;
	endtask : send
endmodule : pdc_ctl_model

// File: tb/pdc_channel_core_test.sv
/* bench for the channel core: register port tasks and link traffic.
   assumes pdc_pkg and the controller model are compiled first. */
`timescale 1ns/1ps
module pdc_channel_core_test;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        clk_en = 1'b1;
	logic        rx_p, rx_n, tx_p, tx_n;
	logic [7:0]  request_pins;
	logic [8:0]  a_in, a_out, a_oe, b_in, b_out, b_oe;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	int          error_cnt = 0;
	int          samples_checked = 0;
	localparam logic [71:0] D1A = 72'h123456789ABCDEF012;
	localparam logic [71:0] D1B = 72'hFEDCBA9876543210ED;
	localparam logic [71:0] D2A = 72'h0F0F0F0F0F0F0F0F0F;
	localparam logic [71:0] D2B = 72'h155AA55AA55AA55AA5;
	always #20 clock = ~clock;
	pdc_ctl_model ctl (.rx_p(rx_p), .rx_n(rx_n), .tx_p(tx_p), .tx_n(tx_n), .request_pins(request_pins),
		.lane_a(a_in), .lane_b(b_in));
	pdc_channel_core #(.ROWS(16), .COLS(8)) dut (.clock(clock), .rst(rst), .clk_en(clk_en),
		.receive_clock_pair_from_master_p(rx_p), .receive_clock_pair_from_master_n(rx_n),
		.transmit_clock_pair_to_master_p(tx_p), .transmit_clock_pair_to_master_n(tx_n),
		.request_pins(request_pins), .data_byte_lane_a_in(a_in), .data_byte_lane_a_out(a_out),
		.data_byte_lane_a_oe(a_oe), .data_byte_lane_b_in(b_in), .data_byte_lane_b_out(b_out),
		.data_byte_lane_b_oe(b_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic conclude();
		if (error_cnt == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		check(what, exp, reg_rdata);
	endtask : rd
	function automatic logic [39:0] cpk(input logic [3:0] op, input logic sel, input logic [15:0] low);
		return {1'b1, 5'h03, 5'h04, 6'h02, op, 2'b00, sel, low};
	endfunction : cpk
	task automatic row(input logic [1:0] fr, input logic [4:0] bank, input logic open, input logic [11:0] low);
		ctl.send(1'b0, {16'h0, fr, 4'h3, bank, open, low}, 1'b0, 72'h0, 72'h0);
		repeat (8) @(posedge clock);
	endtask : row
	task automatic col(input logic [3:0] op, input logic sel, input logic [15:0] low, input logic w,
		input logic [71:0] a, input logic [71:0] b);
		ctl.send(1'b1, cpk(op, sel, low), w, a, b);
		repeat (8) @(posedge clock);
	endtask : col
	task automatic burst(input logic [71:0] ea, input logic [71:0] eb);
		logic [71:0] pa, pb;
		int n;
		pa = ~ea;
		pb = ~eb;
		n = 0;
		while (a_oe !== 9'h1FF)
		begin
			@(posedge clock);
			n++;
			if (n > 300)
			begin
				check("read start", 32'h1, 32'h0);
				conclude();
			end
		end
		// sample mid-beat, one link period apart
		repeat (4) @(posedge clock);
		for (int k = 0; k < 8; k++)
		begin
			check("lane a beat", {23'h0, pa[k*9 +: 9]}, {23'h0, a_out});
			check("lane b beat", {23'h0, pb[k*9 +: 9]}, {23'h0, b_out});
			check("read oe", 32'h3FFFF, {14'h0, a_oe, b_oe});
			repeat (8) @(posedge clock);
		end
		check("oe released", 32'h0, {14'h0, a_oe, b_oe});
	endtask : burst
	initial
	begin
		repeat (5) @(posedge clock);
		check("idle lane a", 32'h1FF, {23'h0, a_out});
		check("idle oe", 32'h0, {14'h0, a_oe, b_oe});
		rst <= 1'b0;
		rd(pdc_pkg::REG_DEV_ID, 32'h0, "device id");
		rd(pdc_pkg::REG_ROW_CNT, 32'h0, "row counter");
		wr(pdc_pkg::REG_DEV_ID, 32'hFFFFFFE3);
		rd(pdc_pkg::REG_DEV_ID, 32'h3, "device id");
		@(posedge clock);
		clk_en <= 1'b0;
		// a frozen core must ignore a register write
		wr(pdc_pkg::REG_DEV_ID, 32'h00000007);
		clk_en <= 1'b1;
		rd(pdc_pkg::REG_DEV_ID, 32'h3, "frozen device id");
		wr(pdc_pkg::REG_ROW_CNT, 32'h000015A5);
		rd(pdc_pkg::REG_ROW_CNT, 32'h1A5, "row counter");
		wr(pdc_pkg::REG_OPEN, 32'hFFFFFFFF);
		rd(4'h2, 32'h0, "unmapped");
		row(2'b10, 5'h04, 1'b1, 12'h00A);
		rd(pdc_pkg::REG_OPEN, 32'h0, "open banks");
		row(2'b01, 5'h04, 1'b1, 12'h00A);
		rd(pdc_pkg::REG_OPEN, 32'h10, "open banks");
		row(2'b01, 5'h05, 1'b1, 12'h003);
		rd(pdc_pkg::REG_OPEN, 32'h10, "open banks");
		rd(pdc_pkg::REG_STATUS, 32'h4, "status");
		wr(pdc_pkg::REG_STATUS, 32'h4);
		row(2'b11, 5'h10, 1'b1, 12'h001);
		rd(pdc_pkg::REG_OPEN, 32'h10010, "open banks");
		rd(pdc_pkg::REG_STATUS, 32'h0, "status");
		row(2'b01, 5'h10, 1'b0, 12'h001);
		rd(pdc_pkg::REG_OPEN, 32'h10, "open banks");
		col(4'h1, 1'b0, 16'h0000, 1'b1, D1A, D1B);
		rd(pdc_pkg::REG_STATUS, 32'h1, "status");
		col(4'h0, 1'b0, 16'h0000, 1'b0, 72'h0, 72'h0);
		rd(pdc_pkg::REG_STATUS, 32'h0, "status");
		col(4'h1, 1'b1, 16'h0FF0, 1'b1, D2A, D2B);
		col(4'h0, 1'b0, 16'h0000, 1'b0, 72'h0, 72'h0);
		ctl.send(1'b1, cpk(4'h6, 1'b0, 16'h0000), 1'b0, 72'h0, 72'h0);
		burst({D1A[71:36], D2A[35:0]}, {D2B[71:36], D1B[35:0]});
		rd(pdc_pkg::REG_OPEN, 32'h0, "open banks");
		row(2'b01, 5'h04, 1'b1, 12'h00A);
		col(4'h0, 1'b0, {1'b0, 5'h03, 5'h04, 5'h01}, 1'b0, 72'h0, 72'h0);
		rd(pdc_pkg::REG_OPEN, 32'h0, "open banks");
		conclude();
	end
endmodule : pdc_channel_core_test
